/* rtl/tam_regs.vh */
`ifndef TAM_REGS_VH
`define TAM_REGS_VH

// command byte offsets
`define TAM_OFS_ALARM2_MASK       8'h0D
`define TAM_OFS_ALARM3_MASK       8'h0E
`define TAM_OFS_LOCAL_LIMIT       8'h40
`define TAM_OFS_R1_ALARM1_LIMIT   8'h41
`define TAM_OFS_R2_ALARM1_LIMIT   8'h42
`define TAM_OFS_R1_ALARM23_LIMIT  8'h49
`define TAM_OFS_R2_ALARM23_LIMIT  8'h4A
`define TAM_OFS_COMMON_HYST       8'h5A
`define TAM_OFS_MAKER_CODE        8'hFE
`define TAM_OFS_REVISION_CODE     8'hFF

// power-on values
`define TAM_RST_ALARM2_MASK       8'h00
`define TAM_RST_ALARM3_MASK       8'h07
`define TAM_RST_LOCAL_LIMIT       8'h55
`define TAM_RST_ALARM1_LIMIT      8'h6E
`define TAM_RST_ALARM23_LIMIT     8'h55
`define TAM_RST_COMMON_HYST       8'h0A

// writable bits of the mixed registers
`define TAM_WMASK_ALARM_MASK      8'h07
`define TAM_WMASK_LOCAL_LIMIT     8'h7F
`define TAM_WMASK_COMMON_HYST     8'h1F

// channel field positions inside the mask registers
`define TAM_BIT_LOCAL             0
`define TAM_BIT_REMOTE1           1
`define TAM_BIT_REMOTE2           2

// arbitrary identity values, not tied to any real part
`define TAM_ID_MAKER              8'h3C
`define TAM_ID_REVISION           8'h21

`endif

/* rtl/tam_chan_cmp.v */
`timescale 1ns/1ns
`default_nettype none

module tam_chan_cmp (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // conversion result
  input  wire       update,
  input  wire [7:0] reading,
  // thresholds
  input  wire [7:0] limit,
  input  wire [7:0] hyst,
  // status bit
  output reg        status_q
);

  reg  [8:0] clr_diff;
  reg  [7:0] clr_thr;
  reg        status_d;

  // clear threshold sits hyst below the limit; saturates at zero, so a
  // limit below the hysteresis keeps a set bit latched until limit is raised
  always @* begin
    clr_diff = {1'b0, limit} - {1'b0, hyst};
    clr_thr  = clr_diff[8] ? 8'h00 : clr_diff[7:0];
  end

  // set at or above limit, clear only below the lowered threshold
  always @* begin
    status_d = status_q;
    if (update) begin
      if (reading >= limit) begin
        status_d = 1'b1;
      end else if (reading < clr_thr) begin
        status_d = 1'b0;
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= 1'b0;
    end else begin
      status_q <= status_d;
    end
  end

endmodule // tam_chan_cmp

`default_nettype wire

/* rtl/tam_limits.v */
`timescale 1ns/1ns
`default_nettype none
`include "tam_regs.vh"

module tam_limits (
  // clock and reset
  input  wire       SYS_CLK,
  input  wire       RESETN,
  // command byte register port from the management bus engine
  input  wire [7:0] CMD_ADDR,
  input  wire       CMD_WR,
  input  wire [7:0] CMD_WDATA,
  output reg  [7:0] CMD_RD_DATA,
  // conversion results, whole degrees, unsigned
  input  wire       CONV_DONE,
  input  wire [7:0] LOCAL_TEMP,
  input  wire [7:0] REMOTE1_TEMP,
  input  wire [7:0] REMOTE2_TEMP,
  // alarm-1 mask held outside this block
  input  wire [2:0] ALARM1_MASK,
  // alarm pins, active low
  output reg        ALARM_OUT_1_N,
  output reg        ALARM_OUT_2_N,
  output reg        ALARM_OUT_3_N,
  // status bits, {remote2, remote1, local}
  output wire [2:0] ALARM1_STATUS,
  output wire [2:0] ALARM2_STATUS,
  output wire [2:0] ALARM3_STATUS
);

  // programmable registers
  reg  [7:0] alarm2_mask_q;
  reg  [7:0] alarm3_mask_q;
  reg  [7:0] local_limit_q;
  reg  [7:0] remote1_alarm1_limit_q;
  reg  [7:0] remote2_alarm1_limit_q;
  reg  [7:0] remote1_alarm23_limit_q;
  reg  [7:0] remote2_alarm23_limit_q;
  reg  [7:0] common_hysteresis_q;

  // status from the comparators
  wire       local_alarm1_status;
  wire       remote1_alarm1_status;
  wire       remote2_alarm1_status;
  wire       local_alarm2_status;
  wire       remote1_alarm2_status;
  wire       remote2_alarm2_status;
  wire [2:0] alarm1_vec;
  wire [2:0] alarm23_vec;

  // one address compare used by the write path; the read path decodes with its own case
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // read mux; reserved bits come back as stored zeros, the read-only identity codes as constants
  function [7:0] read_mux;
    input [7:0] addr;
    begin
      case (addr)
        `TAM_OFS_ALARM2_MASK:      read_mux = alarm2_mask_q;
        `TAM_OFS_ALARM3_MASK:      read_mux = alarm3_mask_q;
        `TAM_OFS_LOCAL_LIMIT:      read_mux = local_limit_q;
        `TAM_OFS_R1_ALARM1_LIMIT:  read_mux = remote1_alarm1_limit_q;
        `TAM_OFS_R2_ALARM1_LIMIT:  read_mux = remote2_alarm1_limit_q;
        `TAM_OFS_R1_ALARM23_LIMIT: read_mux = remote1_alarm23_limit_q;
        `TAM_OFS_R2_ALARM23_LIMIT: read_mux = remote2_alarm23_limit_q;
        `TAM_OFS_COMMON_HYST:      read_mux = common_hysteresis_q;
        `TAM_OFS_MAKER_CODE:       read_mux = `TAM_ID_MAKER;
        `TAM_OFS_REVISION_CODE:    read_mux = `TAM_ID_REVISION;
        default:                   read_mux = 8'h00;
      endcase
    end
  endfunction

  // register writes; the write masks keep reserved bits at zero so no
  // read path needs its own masking
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      alarm2_mask_q           <= `TAM_RST_ALARM2_MASK;
      alarm3_mask_q           <= `TAM_RST_ALARM3_MASK;
      local_limit_q           <= `TAM_RST_LOCAL_LIMIT;
      remote1_alarm1_limit_q  <= `TAM_RST_ALARM1_LIMIT;
      remote2_alarm1_limit_q  <= `TAM_RST_ALARM1_LIMIT;
      remote1_alarm23_limit_q <= `TAM_RST_ALARM23_LIMIT;
      remote2_alarm23_limit_q <= `TAM_RST_ALARM23_LIMIT;
      common_hysteresis_q     <= `TAM_RST_COMMON_HYST;
    end else if (CMD_WR) begin
      if (hit(CMD_ADDR, `TAM_OFS_ALARM2_MASK)) begin
        alarm2_mask_q <= CMD_WDATA & `TAM_WMASK_ALARM_MASK;
      end
      if (hit(CMD_ADDR, `TAM_OFS_ALARM3_MASK)) begin
        alarm3_mask_q <= CMD_WDATA & `TAM_WMASK_ALARM_MASK;
      end
      if (hit(CMD_ADDR, `TAM_OFS_LOCAL_LIMIT)) begin
        local_limit_q <= CMD_WDATA & `TAM_WMASK_LOCAL_LIMIT;
      end
      if (hit(CMD_ADDR, `TAM_OFS_R1_ALARM1_LIMIT)) begin
        remote1_alarm1_limit_q <= CMD_WDATA;
      end
      if (hit(CMD_ADDR, `TAM_OFS_R2_ALARM1_LIMIT)) begin
        remote2_alarm1_limit_q <= CMD_WDATA;
      end
      if (hit(CMD_ADDR, `TAM_OFS_R1_ALARM23_LIMIT)) begin
        remote1_alarm23_limit_q <= CMD_WDATA;
      end
      if (hit(CMD_ADDR, `TAM_OFS_R2_ALARM23_LIMIT)) begin
        remote2_alarm23_limit_q <= CMD_WDATA;
      end
      if (hit(CMD_ADDR, `TAM_OFS_COMMON_HYST)) begin
        common_hysteresis_q <= CMD_WDATA & `TAM_WMASK_COMMON_HYST;
      end
    end
  end

  // registered read data, one cycle behind the address
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_RD_DATA <= 8'h00;
    end else begin
      CMD_RD_DATA <= read_mux(CMD_ADDR);
    end
  end

  // alarm-1 comparators: dedicated remote limits, common local limit
  tam_chan_cmp u_local_a1 (
    .clk      (SYS_CLK),
    .resetn   (RESETN),
    .update   (CONV_DONE),
    .reading  (LOCAL_TEMP),
    .limit    (local_limit_q),
    .hyst     (common_hysteresis_q),
    .status_q (local_alarm1_status)
  );

  tam_chan_cmp u_remote1_a1 (
    .clk      (SYS_CLK),
    .resetn   (RESETN),
    .update   (CONV_DONE),
    .reading  (REMOTE1_TEMP),
    .limit    (remote1_alarm1_limit_q),
    .hyst     (common_hysteresis_q),
    .status_q (remote1_alarm1_status)
  );

  tam_chan_cmp u_remote2_a1 (
    .clk      (SYS_CLK),
    .resetn   (RESETN),
    .update   (CONV_DONE),
    .reading  (REMOTE2_TEMP),
    .limit    (remote2_alarm1_limit_q),
    .hyst     (common_hysteresis_q),
    .status_q (remote2_alarm1_status)
  );

  // alarm-2/3 comparators: one shared set serves both outputs, since the
  // limits and hysteresis are identical the status could never differ
  tam_chan_cmp u_local_a23 (
    .clk      (SYS_CLK),
    .resetn   (RESETN),
    .update   (CONV_DONE),
    .reading  (LOCAL_TEMP),
    .limit    (local_limit_q),
    .hyst     (common_hysteresis_q),
    .status_q (local_alarm2_status)
  );

  tam_chan_cmp u_remote1_a23 (
    .clk      (SYS_CLK),
    .resetn   (RESETN),
    .update   (CONV_DONE),
    .reading  (REMOTE1_TEMP),
    .limit    (remote1_alarm23_limit_q),
    .hyst     (common_hysteresis_q),
    .status_q (remote1_alarm2_status)
  );

  tam_chan_cmp u_remote2_a23 (
    .clk      (SYS_CLK),
    .resetn   (RESETN),
    .update   (CONV_DONE),
    .reading  (REMOTE2_TEMP),
    .limit    (remote2_alarm23_limit_q),
    .hyst     (common_hysteresis_q),
    .status_q (remote2_alarm2_status)
  );

  // status vectors in mask bit order
  assign alarm1_vec    = {remote2_alarm1_status, remote1_alarm1_status, local_alarm1_status};
  assign alarm23_vec   = {remote2_alarm2_status, remote1_alarm2_status, local_alarm2_status};
  assign ALARM1_STATUS = alarm1_vec;
  assign ALARM2_STATUS = alarm23_vec;
  assign ALARM3_STATUS = alarm23_vec;

  // alarm pins: OR of unmasked status, driven low when active; a mask
  // change takes effect on the next edge without waiting for a conversion
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ALARM_OUT_1_N <= 1'b1;
      ALARM_OUT_2_N <= 1'b1;
      ALARM_OUT_3_N <= 1'b1;
    end else begin
      ALARM_OUT_1_N <= ~|(alarm1_vec & ~ALARM1_MASK);
      ALARM_OUT_2_N <= ~|(alarm23_vec & ~alarm2_mask_q[2:0]);
      ALARM_OUT_3_N <= ~|(alarm23_vec & ~alarm3_mask_q[2:0]);
    end
  end

endmodule // tam_limits

`default_nettype wire

/* bench/tam_host.sv */
`timescale 1ns/1ns
`default_nettype none
module tam_host (
  // clock and answer
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  // command port
  output var  logic [7:0] addr,
  output var  logic       wr,
  output var  logic [7:0] wdata
);
  initial begin
    {addr, wr, wdata} = '0;
  end
  // one-cycle strobe; stale data is inverted so nothing leans on it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk);
    {wdata, wr} = {~d, 1'b0};
  endtask
  // address held across the edge that registers the answer
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rd_data;
  endtask
endmodule // tam_host
`default_nettype wire

/* bench/tam_limits_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module tam_chk (
  // clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RESETN,
  // register port
  input wire logic [7:0] CMD_ADDR,
  input wire logic [7:0] CMD_RD_DATA,
  // conversion side
  input wire logic       CONV_DONE,
  input wire logic [7:0] LOCAL_TEMP,
  input wire logic [2:0] ALARM1_MASK,
  // alarms
  input wire logic       ALARM_OUT_1_N,
  input wire logic       ALARM_OUT_2_N,
  input wire logic       ALARM_OUT_3_N,
  input wire logic [2:0] ALARM1_STATUS,
  input wire logic [2:0] ALARM2_STATUS,
  input wire logic [2:0] ALARM3_STATUS
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // pins lag status by one cycle
  out1_masked_or_a: assert property (ALARM_OUT_1_N == !(|$past(ALARM1_STATUS & ~ALARM1_MASK)))
    else $error("alarm 1 pin wrong");
  out2_idle_a: assert property ($past(ALARM2_STATUS) == 3'h0 |-> ALARM_OUT_2_N)
    else $error("alarm 2 pin low without cause");
  out3_idle_a: assert property ($past(ALARM3_STATUS) == 3'h0 |-> ALARM_OUT_3_N)
    else $error("alarm 3 pin low without cause");
  // alarms 2 and 3 share their limits
  status_pair_a: assert property (ALARM2_STATUS == ALARM3_STATUS)
    else $error("alarm 2 and 3 status differ");
  status_hold_a: assert property (!$past(CONV_DONE) |-> $stable({ALARM1_STATUS, ALARM2_STATUS}))
    else $error("status moved without a conversion");
  // local limit never exceeds 127
  local_set_a: assert property (CONV_DONE && LOCAL_TEMP[7] |=> ALARM2_STATUS[0] && ALARM1_STATUS[0])
    else $error("local status not set");
  // reserved bits read zero
  mask_rsvd_a: assert property ($past(CMD_ADDR) inside {8'h0D, 8'h0E} |-> CMD_RD_DATA[7:3] == 5'h00)
    else $error("mask reserved bits set");
  limit_bit7_a: assert property ($past(CMD_ADDR) == 8'h40 |-> !CMD_RD_DATA[7])
    else $error("local limit bit 7 set");
  hyst_rsvd_a: assert property ($past(CMD_ADDR) == 8'h5A |-> CMD_RD_DATA[7:5] == 3'h0)
    else $error("hysteresis upper bits set");
endmodule // tam_chk
bind tam_limits tam_chk tam_chk_inst (.SYS_CLK, .RESETN, .CMD_ADDR, .CMD_RD_DATA, .CONV_DONE, .LOCAL_TEMP,
  .ALARM1_MASK, .ALARM_OUT_1_N, .ALARM_OUT_2_N, .ALARM_OUT_3_N, .ALARM1_STATUS, .ALARM2_STATUS, .ALARM3_STATUS);
`default_nettype wire

/* bench/tam_limits_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tam_regs.vh"
module tam_limits_tb;
  logic        SYS_CLK, RESETN, CMD_WR, CONV_DONE, ALARM_OUT_1_N, ALARM_OUT_2_N, ALARM_OUT_3_N;
  logic [7:0]  CMD_ADDR, CMD_WDATA, CMD_RD_DATA, LOCAL_TEMP, REMOTE1_TEMP, REMOTE2_TEMP, rd;
  logic [2:0]  ALARM1_MASK, ALARM1_STATUS, ALARM2_STATUS, ALARM3_STATUS;
  int          mismatches = 0, samples_checked = 0, cyc = 0;
  wire  [15:0] alarms = {4'h0, ALARM1_STATUS, ALARM2_STATUS, ALARM3_STATUS, ALARM_OUT_1_N, ALARM_OUT_2_N,
                         ALARM_OUT_3_N};
  // address, reset value, written value, read-back
  logic [31:0] rows [11] = '{32'h0D00FF07, 32'h0E07F800, 32'h4055FF7F, 32'h416EA5A5, 32'h426E5A5A,
    32'h49558080, 32'h4A558181, 32'h5A0AFF1F, {8'hFE, `TAM_ID_MAKER, 8'h00, `TAM_ID_MAKER},
    {8'hFF, `TAM_ID_REVISION, 8'h5A, `TAM_ID_REVISION}, 32'h33007700};
  tam_limits tam_limits_inst (.SYS_CLK, .RESETN, .CMD_ADDR, .CMD_WR, .CMD_WDATA, .CMD_RD_DATA, .CONV_DONE,
    .LOCAL_TEMP, .REMOTE1_TEMP, .REMOTE2_TEMP, .ALARM1_MASK, .ALARM_OUT_1_N, .ALARM_OUT_2_N, .ALARM_OUT_3_N,
    .ALARM1_STATUS, .ALARM2_STATUS, .ALARM3_STATUS);
  tam_host tam_host_inst (.clk(SYS_CLK), .rd_data(CMD_RD_DATA), .addr(CMD_ADDR), .wr(CMD_WR), .wdata(CMD_WDATA));
  // clock and hang guard
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      test_done;
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one conversion; returns once the pins have settled
  task automatic conv(input logic [7:0] l, input logic [7:0] r1, input logic [7:0] r2);
    @(negedge SYS_CLK);
    {LOCAL_TEMP, REMOTE1_TEMP, REMOTE2_TEMP, CONV_DONE} = {l, r1, r2, 1'b1};
    @(negedge SYS_CLK);
    CONV_DONE = 1'b0;
    @(negedge SYS_CLK);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {RESETN, CONV_DONE, LOCAL_TEMP, REMOTE1_TEMP, REMOTE2_TEMP, ALARM1_MASK} = '0;
    repeat (16) @(negedge SYS_CLK);
    RESETN = 1'b1;
    // reset value, write, read back for every register plus one unmapped place
    foreach (rows[i]) begin
      tam_host_inst.rd_reg(rows[i][31:24], rd);
      chk("reset value", {8'h00, rd}, {8'h00, rows[i][23:16]});
      tam_host_inst.wr_reg(rows[i][31:24], rows[i][15:8]);
      tam_host_inst.rd_reg(rows[i][31:24], rd);
      chk("read back", {8'h00, rd}, {8'h00, rows[i][7:0]});
      $display("register test %0d done", i);
    end
    // set at equal limit, one below stays clear, remote 1 masked on alarm 2
    ALARM1_MASK = 3'b101;
    tam_host_inst.wr_reg(8'h0D, 8'h02);
    conv(8'h80, 8'h80, 8'h80);
    chk("alarm set", alarms, 16'h0ADC);
    ALARM1_MASK = 3'b000;
    tam_host_inst.wr_reg(8'h0D, 8'h03);
    tam_host_inst.wr_reg(8'h0E, 8'h03);
    @(negedge SYS_CLK);
    chk("mask change", alarms, 16'h0ADB);
    $display("mask test done");
    // falling readings: hold at the threshold, clear one below it
    conv(8'h60, 8'h61, 8'h00);
    chk("hysteresis hold", alarms, 16'h02DB);
    conv(8'h5F, 8'h60, 8'h00);
    chk("hysteresis clear", alarms, 16'h0007);
    $display("hysteresis test done");
    // both remotes reach their limits; remote 2 passes the alarm 2/3 masks
    conv(8'h00, 8'hA5, 8'h81);
    chk("remote set", alarms, 16'h0DB0);
    $display("remote test done");
    // mid-run reset clears status, raises the pins, restores the shared limit
    RESETN = 1'b0;
    @(negedge SYS_CLK);
    RESETN = 1'b1;
    chk("reset alarms", alarms, 16'h0007);
    tam_host_inst.rd_reg(8'h4A, rd);
    chk("reset limit", {8'h00, rd}, 16'h0055);
    $display("reset test done");
    test_done;
  end
endmodule // tam_limits_tb
`default_nettype wire
